// [hw/ddr_rd_defines.svh]
// Offsets, field positions, reset values and timing counts of the read path
`ifndef DDR_RD_DEFINES_SVH
`define DDR_RD_DEFINES_SVH
// ==========================================================
// Clocks: system clock period and link clock divider
`define CLK_PS 4000
`define CK_HALF 4
`define LINK_TCK_PS (2 * `CK_HALF * `CLK_PS)
// Time to link clocks, rounded up
`define CKS(ps) (((ps) + `LINK_TCK_PS - 1) / `LINK_TCK_PS)
// ==========================================================
// Array timing limits in picoseconds; activate count, burst lengths, prefetch gap, auto-precharge bit
`define T_RCD_PS 15000
`define T_RC_PS 55000
`define T_RRD_PS 7500
`define T_FAW_PS 37500
`define T_RP_PS 15000
`define T_RTP_PS 7500
`define T_RAS_PS 40000
`define FAW_ACTS 4
`define BL_SHORT 4
`define BL_LONG 8
`define PREFETCH_GAP 2
`define AP_BIT 10
// ==========================================================
// Controller register offsets
`define REG_CMD 8'h00
`define REG_STATUS 8'h04
`define REG_CFG 8'h08
`define REG_RDLO 8'h0c
`define REG_RDHI 8'h10
`define REG_RCNT 8'h14
// ==========================================================
// Field positions and reset values
`define CMD_OP_LSB 0
`define CMD_BANK_LSB 2
`define CMD_ADDR_LSB 5
`define CFG_AL_LSB 0
`define CFG_CL_LSB 3
`define CFG_BL8_BIT 6
`define CFG_RESET 7'h18
`define ST_BUSY_BIT 0
`define ST_REFUSED_BIT 1
`define ST_INFLIGHT_BIT 2
`define ST_OPEN_LSB 8
`endif

// [hw/ddr_rd_pkg.sv]
// Types and pin coding shared by both ends of the read-path link
package ddr_rd_pkg;
   typedef logic [7:0] reg_addr_t;
   typedef logic [31:0] word_t;
   typedef logic [2:0] bank_t;
   typedef logic [13:0] row_addr_t;
   typedef enum logic [1:0] {OP_NOP, OP_ACT, OP_READ, OP_PRE} op_t;
   typedef enum {C_IDLE, C_PEND, C_HOLD} ctrl_state_t;

   // Command pins in order {cs_n, ras_n, cas_n, we_n}
   function automatic logic [3:0] pin_encode(input op_t op);
      case (op)
         OP_ACT: return 4'h3;
         OP_READ: return 4'h5;
         OP_PRE: return 4'h2;
         default: return 4'h7;
      endcase
   endfunction

   // Deselect and any unknown code count as no operation
   function automatic op_t pin_decode(input logic [3:0] p);
      case (p)
         4'h3: return OP_ACT;
         4'h5: return OP_READ;
         4'h2: return OP_PRE;
         default: return OP_NOP;
      endcase
   endfunction
endpackage

// [hw/ddr_rd_if.sv]
// Link between memory controller and memory device read path
`timescale 1ns/1ps
interface ddr_rd_if
#(
   parameter int DQ_W = 8
);
   logic ck;
   logic [3:0] cmd_pins;
   ddr_rd_pkg::bank_t ba;
   ddr_rd_pkg::row_addr_t a;
   logic [DQ_W-1:0] dq;
   logic dq_oe;
   logic dqs;
   logic dqs_n;
   logic dqs_oe;

   modport ctrl
   (
      output ck, cmd_pins, ba, a,
      input dq, dq_oe, dqs, dqs_n, dqs_oe
   );
   modport dev
   (
      input ck, cmd_pins, ba, a,
      output dq, dq_oe, dqs, dqs_n, dqs_oe
   );
endinterface

// [hw/ddr_rd_sync.sv]
// Two-flop synchroniser with edge detection on bit 0
`timescale 1ns/1ps
module ddr_rd_sync
#(
   parameter int W = 1
)
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q,
   output logic o_rise,
   output logic o_fall
);
   logic [W-1:0] meta;
   logic last;

   if (W < 1) $error("ddr_rd_sync: W must be at least 1");

   // ==========================================================
   // Stages; meta feeds only the second flop
   always_ff @(posedge i_clk)
      if (i_srst)
      begin
         meta <= '0;
         o_q <= '0;
         last <= 1'b0;
      end
      else if (i_ce)
      begin
         meta <= i_d;
         o_q <= meta;
         last <= o_q[0];
      end

   // Edges seen only on the settled copy
   assign o_rise = o_q[0] && !last;
   assign o_fall = !o_q[0] && last;
endmodule

// [hw/ddr_rd_dev.sv]
// Memory device end: bank rows, read latency, data and strobe output
`timescale 1ns/1ps
`include "ddr_rd_defines.svh"
module ddr_rd_dev
#(
   parameter int DQ_W = 8
)
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [2:0] i_al,
   input wire logic [2:0] i_cl,
   input wire logic i_bl8,
   output logic [7:0] o_bank_open,
   output logic o_burst,
   ddr_rd_if.dev link
);
   import ddr_rd_pkg::*;

   localparam int NB = 8;
   localparam int LD = 16;
   localparam logic [5:0] N_RAS = 6'(`CKS(`T_RAS_PS));
   localparam logic [5:0] N_RTP = 6'(`CKS(`T_RTP_PS));

   if (DQ_W < 1 || DQ_W > 8) $error("ddr_rd_dev: DQ_W must be 1..8");

   logic [21:0] q;
   logic ck_rise;
   logic ck_fall;
   op_t op;
   bank_t ba;
   row_addr_t a;
   logic [3:0] rl_idx;
   logic [5:0] hb;
   logic [LD-1:0] due;
   bank_t due_bank [LD];
   logic [9:0] due_col [LD];
   logic [5:0] ras_w [NB];
   logic [5:0] rtp_w [NB];
   logic [5:0] ap_w [NB];
   logic [NB-1:0] ap_pend;
   logic [3:0] left;
   logic [2:0] beat;
   bank_t cur_bank;
   logic [9:0] cur_col;

   // Pins arrive from the other party, so all pass the synchroniser
   ddr_rd_sync #(.W(22)) u_sync
   (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_d({link.a, link.ba, link.cmd_pins, link.ck}),
      .o_q(q),
      .o_rise(ck_rise),
      .o_fall(ck_fall)
   );

   // Command fields, valid at a rising link edge
   assign op = ck_rise ? pin_decode(q[4:1]) : OP_NOP;
   assign ba = q[7:5];
   assign a = q[21:8];
   assign hb = i_bl8 ? 6'(`BL_LONG / 2) : 6'(`BL_SHORT / 2);
   // Latency of zero still takes slot 0, as latency one does; settings below two lack preamble
   assign rl_idx = (i_al + i_cl == 4'h0) ? 4'h0 : 4'(i_al + i_cl - 3'h1);
   assign o_burst = link.dq_oe;

   // Data pattern from bank, column and beat, sequential order
   function automatic logic [DQ_W-1:0] beat_data(input bank_t b,
      input logic [9:0] c, input logic [2:0] n);
      logic [12:0] w;
      w = {b, c} + 13'(n);
      return w[DQ_W-1:0];
   endfunction

   function automatic logic [5:0] dec(input logic [5:0] v);
      return (v == 6'h0) ? v : v - 6'h1;
   endfunction

   // ==========================================================
   // Read latency line, one slot per rising link edge
   always_ff @(posedge i_clk)
      if (i_srst)
      begin
         due <= '0;
         for (int i = 0; i < LD; i++)
         begin
            due_bank[i] <= '0;
            due_col[i] <= '0;
         end
      end
      else if (i_ce && ck_rise)
      begin
         for (int i = 0; i < LD; i++)
         begin
            // First beat lands AL + CL edges after the command
            if (op == OP_READ && 4'(i) == rl_idx)
            begin
               due[i] <= 1'b1;
               due_bank[i] <= ba;
               due_col[i] <= a[9:0];
            end
            else if (i < LD - 1)
            begin
               due[i] <= due[i + 1];
               due_bank[i] <= due_bank[i + 1];
               due_col[i] <= due_col[i + 1];
            end
            else
               due[i] <= 1'b0;
         end
      end

   // ==========================================================
   // Bank rows and internal precharge after auto-precharge reads
   always_ff @(posedge i_clk)
      if (i_srst)
      begin
         o_bank_open <= '0;
         ap_pend <= '0;
         for (int i = 0; i < NB; i++)
         begin
            ras_w[i] <= '0;
            rtp_w[i] <= '0;
            ap_w[i] <= '0;
         end
      end
      else if (i_ce && ck_rise)
      begin
         for (int i = 0; i < NB; i++)
         begin
            ras_w[i] <= dec(ras_w[i]);
            rtp_w[i] <= dec(rtp_w[i]);
            ap_w[i] <= dec(ap_w[i]);
            // Start waits for AL+BL/2, row active time and tRTP
            if (ap_pend[i] && ap_w[i] <= 6'h1 && ras_w[i] <= 6'h1
               && rtp_w[i] <= 6'h1)
            begin
               ap_pend[i] <= 1'b0;
               o_bank_open[i] <= 1'b0;
            end
         end
         case (op)
            OP_ACT:
            begin
               o_bank_open[ba] <= 1'b1;
               ras_w[ba] <= N_RAS;
            end
            OP_READ:
            begin
               // Address bit picks closing the row or keeping it
               ap_pend[ba] <= a[`AP_BIT];
               ap_w[ba] <= 6'(i_al) + hb;
               rtp_w[ba] <= 6'(i_al) + N_RTP
                  + (i_bl8 ? 6'(`PREFETCH_GAP) : 6'h0);
            end
            OP_PRE:
            begin
               o_bank_open[ba] <= 1'b0;
               ap_pend[ba] <= 1'b0;
            end
            default:
            begin
            end
         endcase
      end

   // ==========================================================
   // Output engine, steps on both link edges
   always_ff @(posedge i_clk)
      if (i_srst)
      begin
         left <= '0;
         beat <= '0;
         cur_bank <= '0;
         cur_col <= '0;
         link.dq <= '0;
         link.dq_oe <= 1'b0;
         link.dqs <= 1'b0;
         link.dqs_n <= 1'b1;
         link.dqs_oe <= 1'b0;
      end
      else if (i_ce && (ck_rise || ck_fall))
      begin
         if (ck_rise && due[0])
         begin
            // New burst also cuts an older one, giving gapless data
            cur_bank <= due_bank[0];
            cur_col <= due_col[0];
            beat <= 3'h1;
            left <= i_bl8 ? 4'(`BL_LONG - 1) : 4'(`BL_SHORT - 1);
            link.dq <= beat_data(due_bank[0], due_col[0], 3'h0);
            link.dq_oe <= 1'b1;
            link.dqs <= 1'b1;
            link.dqs_n <= 1'b0;
            link.dqs_oe <= 1'b1;
         end
         else if (left != 4'h0)
         begin
            // One element per edge, double rate
            link.dq <= beat_data(cur_bank, cur_col, beat);
            beat <= beat + 3'h1;
            left <= left - 4'h1;
            // Odd beats low, so the last carries the postamble
            link.dqs <= ~link.dqs;
            link.dqs_n <= link.dqs;
         end
         else if (ck_rise && due[1])
         begin
            // Preamble one link clock ahead of the first element
            link.dq_oe <= 1'b0;
            link.dqs <= 1'b0;
            link.dqs_n <= 1'b1;
            link.dqs_oe <= 1'b1;
         end
         else if (ck_rise)
         begin
            // Nothing follows: let the lines float
            link.dq_oe <= 1'b0;
            link.dqs <= 1'b0;
            link.dqs_n <= 1'b1;
            link.dqs_oe <= 1'b0;
         end
      end
endmodule

// [hw/ddr_rd_ctrl.sv]
// Memory controller end: command timing, register port, read capture
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "ddr_rd_defines.svh"
module ddr_rd_ctrl
#(
   parameter int DQ_W = 8
)
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire ddr_rd_pkg::reg_addr_t i_addr,
   input wire ddr_rd_pkg::word_t i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output ddr_rd_pkg::word_t o_rdata,
   ddr_rd_if.ctrl link
);
   import ddr_rd_pkg::*;

   localparam int NB = 8;
   localparam int DW = $clog2(`CK_HALF) + 1;
   localparam logic [5:0] N_RCD = 6'(`CKS(`T_RCD_PS));
   localparam logic [5:0] N_RC = 6'(`CKS(`T_RC_PS));
   localparam logic [5:0] N_RRD = 6'(`CKS(`T_RRD_PS));
   localparam logic [5:0] N_FAW = 6'(`CKS(`T_FAW_PS));
   localparam logic [5:0] N_RP = 6'(`CKS(`T_RP_PS));
   localparam logic [5:0] N_RTP = 6'(`CKS(`T_RTP_PS));
   localparam logic [5:0] N_RAS = 6'(`CKS(`T_RAS_PS));
   localparam logic [5:0] GAP = 6'(`PREFETCH_GAP);

   if (DQ_W < 1 || DQ_W > 8) $error("ddr_rd_ctrl: DQ_W must be 1..8");
   if (`CK_HALF < 2) $error("ddr_rd_ctrl: link divider too small");

   logic [DW-1:0] div;
   logic rise_tick;
   logic fall_tick;
   logic [6:0] cfg;
   logic [5:0] al;
   logic [5:0] hb;
   logic [5:0] r2p;
   ctrl_state_t state;
   op_t cmd_op;
   bank_t cmd_bank;
   row_addr_t cmd_addr;
   logic [NB-1:0] open;
   logic [5:0] act_w [NB];
   logic [5:0] rd_w [NB];
   logic [5:0] pre_w [NB];
   logic [5:0] faw_w [`FAW_ACTS];
   logic [5:0] rrd_w;
   logic [5:0] rr_w;
   logic [5:0] fly_w;
   logic faw_free;
   logic [1:0] faw_slot;
   logic illegal;
   logic ready;
   logic issue;
   logic refused;
   logic [DQ_W+1:0] cap;
   logic dqs_rise;
   logic dqs_fall;
   logic [7:0] rbuf [8];
   logic [7:0] rcnt;
   word_t rd_mux;

   function automatic logic [5:0] dec(input logic [5:0] v);
      return (v == 6'h0) ? v : v - 6'h1;
   endfunction

   function automatic logic [5:0] maxf(input logic [5:0] x,
      input logic [5:0] y);
      return (x > y) ? x : y;
   endfunction

   // ==========================================================
   // Link clock divider; commands change on falling edges
   always_ff @(posedge i_clk)
      if (i_srst)
      begin
         div <= '0;
         link.ck <= 1'b0;
      end
      else if (i_ce)
      begin
         if (div == DW'(`CK_HALF - 1))
         begin
            div <= '0;
            link.ck <= ~link.ck;
         end
         else
            div <= div + 1'b1;
      end

   assign rise_tick = (div == DW'(`CK_HALF - 1)) && !link.ck;
   assign fall_tick = (div == DW'(`CK_HALF - 1)) && link.ck;
   assign al = 6'(cfg[`CFG_AL_LSB +: 3]);
   assign hb = cfg[`CFG_BL8_BIT] ? 6'(`BL_LONG / 2) : 6'(`BL_SHORT / 2);
   // Read-to-precharge spacing
   assign r2p = al + hb - GAP + maxf(N_RTP, GAP);

   // ==========================================================
   // Legality and readiness of the pending command
   always_comb
   begin
      faw_free = 1'b0;
      faw_slot = 2'h0;
      for (int i = `FAW_ACTS - 1; i >= 0; i--)
         if (faw_w[i] == 6'h0)
         begin
            faw_free = 1'b1;
            faw_slot = 2'(i);
         end
      // Read to closed row or activate to open row is refused
      illegal = (cmd_op == OP_READ && !open[cmd_bank])
         || (cmd_op == OP_ACT && open[cmd_bank]);
      case (cmd_op)
         // tRC, tRRD and the four-activate window
         OP_ACT: ready = act_w[cmd_bank] == 6'h0 && rrd_w == 6'h0
            && faw_free;
         // tRCD and read spacing keep bursts whole
         OP_READ: ready = rd_w[cmd_bank] == 6'h0 && rr_w == 6'h0;
         // No precharge into a running burst
         OP_PRE: ready = pre_w[cmd_bank] == 6'h0;
         default: ready = 1'b1;
      endcase
   end

   // Sent only once the counters its command checks have run out
   assign issue = state == C_PEND && fall_tick && !illegal && ready;

   // ==========================================================
   // Command sequencer, at most one command every two link clocks
   always_ff @(posedge i_clk)
      if (i_srst)
         state <= C_IDLE;
      else if (i_ce)
         case (state)
            C_IDLE: if (i_wr && i_addr == `REG_CMD) state <= C_PEND;
            C_PEND: if (fall_tick && (illegal || ready)) state <= C_HOLD;
            C_HOLD: if (fall_tick) state <= C_IDLE;
            default: state <= C_IDLE;
         endcase

   // Command latch and pins held for a whole link clock
   always_ff @(posedge i_clk)
      if (i_srst)
      begin
         cmd_op <= OP_NOP;
         cmd_bank <= '0;
         cmd_addr <= '0;
         link.cmd_pins <= pin_encode(OP_NOP);
         link.ba <= '0;
         link.a <= '0;
      end
      else if (i_ce)
      begin
         if (state == C_IDLE && i_wr && i_addr == `REG_CMD)
         begin
            cmd_op <= op_t'(i_wdata[`CMD_OP_LSB +: 2]);
            cmd_bank <= i_wdata[`CMD_BANK_LSB +: 3];
            cmd_addr <= i_wdata[`CMD_ADDR_LSB +: 14];
         end
         if (issue)
         begin
            // Bank, column and auto-precharge bit go out together
            link.cmd_pins <= pin_encode(cmd_op);
            link.ba <= cmd_bank;
            link.a <= cmd_addr;
         end
         else if (fall_tick)
            link.cmd_pins <= pin_encode(OP_NOP);
      end

   // ==========================================================
   // Open rows as the device will see them
   always_ff @(posedge i_clk)
      if (i_srst)
         open <= '0;
      else if (i_ce && issue)
         case (cmd_op)
            OP_ACT: open[cmd_bank] <= 1'b1;
            OP_READ: if (cmd_addr[`AP_BIT]) open[cmd_bank] <= 1'b0;
            OP_PRE: open[cmd_bank] <= 1'b0;
            default: open <= open;
         endcase

   // Spacing counters in link clocks; rise and issue never coincide
   always_ff @(posedge i_clk)
      if (i_srst)
      begin
         for (int i = 0; i < NB; i++)
         begin
            act_w[i] <= '0;
            rd_w[i] <= '0;
            pre_w[i] <= '0;
         end
         for (int i = 0; i < `FAW_ACTS; i++)
            faw_w[i] <= '0;
         rrd_w <= '0;
         rr_w <= '0;
         fly_w <= '0;
      end
      else if (i_ce && rise_tick)
      begin
         for (int i = 0; i < NB; i++)
         begin
            act_w[i] <= dec(act_w[i]);
            rd_w[i] <= dec(rd_w[i]);
            pre_w[i] <= dec(pre_w[i]);
         end
         for (int i = 0; i < `FAW_ACTS; i++)
            faw_w[i] <= dec(faw_w[i]);
         rrd_w <= dec(rrd_w);
         rr_w <= dec(rr_w);
         fly_w <= dec(fly_w);
      end
      else if (i_ce && issue)
         case (cmd_op)
            OP_ACT:
            begin
               act_w[cmd_bank] <= maxf(act_w[cmd_bank], N_RC);
               rd_w[cmd_bank] <= maxf(rd_w[cmd_bank], N_RCD);
               pre_w[cmd_bank] <= maxf(pre_w[cmd_bank], N_RAS);
               rrd_w <= N_RRD;
               faw_w[faw_slot] <= N_FAW;
            end
            OP_READ:
            begin
               // Next read no sooner than one whole burst, BL/2 link clocks
               rr_w <= hb;
               pre_w[cmd_bank] <= maxf(pre_w[cmd_bank], r2p);
               fly_w <= al + 6'(cfg[`CFG_CL_LSB +: 3]) + hb + 6'h1;
               if (cmd_addr[`AP_BIT])
               begin
                  // Row reopens after internal precharge and tRP
                  // Never before the device's own precharge point
                  act_w[cmd_bank] <= maxf(act_w[cmd_bank],
                     maxf(pre_w[cmd_bank], r2p) + N_RP);
                  rd_w[cmd_bank] <= maxf(rd_w[cmd_bank],
                     maxf(pre_w[cmd_bank], r2p) + N_RP);
               end
            end
            OP_PRE:
            begin
               act_w[cmd_bank] <= maxf(act_w[cmd_bank], N_RP);
               rd_w[cmd_bank] <= maxf(rd_w[cmd_bank], N_RP);
            end
            default:
            begin
            end
         endcase

   // ==========================================================
   // Configuration and refusal flag; a new refusal beats the clear
   always_ff @(posedge i_clk)
      if (i_srst)
      begin
         cfg <= `CFG_RESET;
         refused <= 1'b0;
      end
      else if (i_ce)
      begin
         if (i_wr && i_addr == `REG_CFG)
            cfg <= i_wdata[6:0];
         refused <= (refused && !(i_wr && i_addr == `REG_STATUS
            && i_wdata[`ST_REFUSED_BIT]))
            || (state == C_PEND && fall_tick && illegal)
            || (state != C_IDLE && i_wr && i_addr == `REG_CMD);
      end

   // ==========================================================
   // Read capture: one element per strobe transition
   ddr_rd_sync #(.W(DQ_W + 2)) u_sync
   (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_d({link.dq, link.dqs_oe, link.dqs}),
      .o_q(cap),
      .o_rise(dqs_rise),
      .o_fall(dqs_fall)
   );

   // Preamble alone has no transition, so nothing is taken early
   always_ff @(posedge i_clk)
      if (i_srst)
      begin
         rcnt <= '0;
         for (int i = 0; i < 8; i++)
            rbuf[i] <= '0;
      end
      else if (i_ce)
      begin
         if ((dqs_rise || dqs_fall) && cap[1])
         begin
            rbuf[(i_wr && i_addr == `REG_RCNT) ? 3'h0 : rcnt[2:0]]
               <= 8'(cap[DQ_W+1:2]);
            rcnt <= (i_wr && i_addr == `REG_RCNT) ? 8'h1 : rcnt + 8'h1;
         end
         else if (i_wr && i_addr == `REG_RCNT)
            rcnt <= '0;
      end

   // ==========================================================
   // Register read port, data one cycle after the strobe
   always_comb
   begin
      rd_mux = '0;
      case (i_addr)
         `REG_CMD: rd_mux = word_t'({cmd_addr, cmd_bank, cmd_op});
         `REG_STATUS:
         begin
            rd_mux[`ST_BUSY_BIT] = state != C_IDLE;
            rd_mux[`ST_REFUSED_BIT] = refused;
            // Software starts writes only once this drops
            rd_mux[`ST_INFLIGHT_BIT] = fly_w != 6'h0;
            rd_mux[`ST_OPEN_LSB +: NB] = open;
         end
         `REG_CFG: rd_mux = word_t'(cfg);
         `REG_RDLO: rd_mux = {rbuf[3], rbuf[2], rbuf[1], rbuf[0]};
         `REG_RDHI: rd_mux = {rbuf[7], rbuf[6], rbuf[5], rbuf[4]};
         `REG_RCNT: rd_mux = word_t'(rcnt);
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge i_clk)
      if (i_srst)
         o_rdata <= '0;
      else if (i_ce)
         o_rdata <= i_rd ? rd_mux : '0;
endmodule

// [verification/ddr_rd_props.sv]
// Link protocol checks between the controller and device ends
`timescale 1ns/1ps
module ddr_rd_props
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic ck,
   input wire logic [3:0] cmd_pins,
   input wire logic dq_oe,
   input wire logic dqs,
   input wire logic dqs_n,
   input wire logic dqs_oe
);
   // ==========================================
   // Command pins, strobe framing, read latency
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   a_pins_ck_low: assert property ($changed(cmd_pins) |-> !ck)
      else $error("command pins moved while link clock high");
   // Pins first seen changed, then seven more samples, then no operation
   a_cmd_one_ck: assert property ($changed(cmd_pins)
      && cmd_pins != 4'h7 |=> $stable(cmd_pins)[*7] ##1 cmd_pins == 4'h7)
      else $error("command did not stand one link clock");
   // Fixed config AL0 CL3: pin change, rise 4 later, RL 3, lag 3
   a_read_lat: assert property ($changed(cmd_pins)
      && cmd_pins == 4'h5 |-> ##[24:34] dq_oe)
      else $error("read data missing after read latency");
   a_pre_levels: assert property ($rose(dqs_oe) |-> !dqs && !dq_oe)
      else $error("preamble levels wrong");
   a_dqs_pair: assert property (dqs_oe |-> dqs != dqs_n)
      else $error("strobe pair not complementary");
   a_beat0_high: assert property ($rose(dq_oe)
      |-> dqs && $past(dqs_oe))
      else $error("first beat without preamble or high strobe");
   // Half a link clock is four system clocks per beat
   a_beat_len: assert property ($rose(dq_oe) |-> dqs[*4] ##1 !dqs)
      else $error("first beat not half a link clock");
   a_release: assert property ($fell(dq_oe) |-> !dqs_oe && dqs_n)
      else $error("strobe still driven after data release");
endmodule

// [verification/tb_top.sv]
// Self-checking bench joining controller and device over the link
`timescale 1ns/1ps
`include "ddr_rd_defines.svh"
module tb_top;
   import ddr_rd_pkg::*;
   logic i_clk;
   logic i_srst;
   reg_addr_t i_addr;
   word_t i_wdata;
   logic i_wr;
   logic i_rd;
   word_t o_rdata;
   logic bl8;
   logic [7:0] o_bank_open;
   logic burst;
   logic prev_oe = 1'b0;
   int mismatches = 0;
   int num_checks = 0;
   int bursts = 0;
   ddr_rd_if link();
   ddr_rd_ctrl u_ddr_rd_ctrl(.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .link(link));
   // Latency fixed at AL0 CL3 to match the controller's reset config
   ddr_rd_dev u_ddr_rd_dev(.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1),
      .i_al(3'h0), .i_cl(3'h3), .i_bl8(bl8), .o_bank_open(o_bank_open),
      .o_burst(burst), .link(link));
   ddr_rd_props u_ddr_rd_props(.i_clk(i_clk), .i_srst(i_srst), .ck(link.ck),
      .cmd_pins(link.cmd_pins), .dq_oe(link.dq_oe), .dqs(link.dqs),
      .dqs_n(link.dqs_n), .dqs_oe(link.dqs_oe));
   // ==========================================
   // Clock and data-burst counter
   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // A gapless pair of reads shows as one rise of the data enable
   always @(posedge i_clk)
   begin
      if (link.dq_oe === 1'b1 && prev_oe !== 1'b1) bursts++;
      prev_oe <= link.dq_oe;
   end
   // ==========================================
   // Register port tasks
   task automatic check(input word_t got, input word_t exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input reg_addr_t ad, input word_t d);
      @(posedge i_clk);
      i_addr <= ad;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input reg_addr_t ad, output word_t v);
      @(posedge i_clk);
      i_addr <= ad;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   task automatic rchk(input reg_addr_t ad, input word_t exp);
      word_t v;
      rd(ad, v);
      check(v, exp);
   endtask
   // Busy is polled quickly so a second read still lands gapless
   task automatic issue(input op_t op, input bank_t b, input int ad);
      word_t v;
      wr(`REG_CMD, {13'h0, ad[13:0], b, op});
      v = 32'h1;
      for (int i = 0; i < 40 && v[0] !== 1'b0; i++) rd(`REG_STATUS, v);
      check(word_t'(v[0]), 32'h0);
   endtask
   task automatic drain();
      int i;
      int j;
      for (i = 0; i < 99 && link.dq_oe !== 1'b1; i++) @(posedge i_clk);
      for (j = 0; j < 99 && link.dq_oe !== 1'b0; j++) @(posedge i_clk);
      // Both waits in time, burst flag down with the lines
      check(word_t'(i < 99 && j < 99 && burst === 1'b0), 32'h1);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset_refuse();
      rchk(`REG_CFG, 32'h18);
      rchk(8'hfc, 32'h0);
      issue(OP_READ, 3'h0, 0);
      rchk(`REG_STATUS, 32'h2);
      wr(`REG_STATUS, 32'h2);
      check(word_t'(bursts), 32'h0);
   endtask
   task automatic t_act_reads();
      issue(OP_ACT, 3'h1, 5);
      rchk(`REG_STATUS, 32'h200);
      wr(`REG_RCNT, 32'h0);
      issue(OP_READ, 3'h1, 8);
      drain();
      rchk(`REG_RCNT, 32'h4);
      rchk(`REG_RDLO, 32'h0b0a0908);
      wr(`REG_RCNT, 32'h0);
      issue(OP_READ, 3'h1, 8);
      issue(OP_READ, 3'h1, 12);
      drain();
      rchk(`REG_RDHI, 32'h0f0e0d0c);
      check(word_t'(bursts), 32'h2);
      issue(OP_READ, 3'h1, 32'h400);
      drain();
      check(word_t'(o_bank_open), 32'h0);
   endtask
   task automatic t_bl8_pre();
      @(posedge i_clk);
      bl8 <= 1'b1;
      wr(`REG_CFG, 32'h58);
      wr(`REG_RCNT, 32'h0);
      issue(OP_ACT, 3'h2, 1);
      issue(OP_READ, 3'h2, 0);
      drain();
      rchk(`REG_RCNT, 32'h8);
      rchk(`REG_RDHI, 32'h07060504);
      issue(OP_PRE, 3'h2, 0);
      rchk(`REG_STATUS, 32'h0);
      issue(OP_ACT, 3'h2, 3);
      rchk(`REG_STATUS, 32'h400);
   endtask
   // ==========================================
   // Verdict, main sequence and watchdog
   task automatic results();
      $display("Checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      i_srst = 1'b1;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      bl8 = 1'b0;
      repeat (4) @(posedge i_clk);
      i_srst <= 1'b0;
      t_reset_refuse();
      t_act_reads();
      t_bl8_pre();
      results();
   end
   initial
   begin
      #100000;
      mismatches++;
      results();
   end
endmodule
